// ==== hw/psda_pkg.sv ====
// package for the program space data access block
// assumes one core clock; constants shared by design and bench
package psda_pkg;
    // register port indices
    localparam logic [3:0] REG_CORE_CTRL = 4'h0;
    localparam logic [3:0] REG_WIN_PAGE = 4'h1;
    localparam logic [3:0] REG_TBL_PAGE = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    // field positions
    localparam int WIN_EN_BIT = 0;
    localparam int CFG_SEL_BIT = 7;
    localparam int ST_WIN_BIT = 2;
    localparam int ST_ZERO_BIT = 3;
    localparam int ST_BUSY_BIT = 4;
    // reset values
    localparam logic [7:0] WIN_PAGE_RST = 8'h00;
    localparam logic [7:0] TBL_PAGE_RST = 8'h00;
    localparam logic WIN_EN_RST = 1'b0;
    // widths
    localparam int PW = 24;
    localparam int DW = 16;
    // data space layout defaults
    localparam logic [15:0] DM_BYTES_DEF = 16'h0100;
    localparam logic [15:0] Y_FIRST_DEF = 16'h0080;
    localparam logic [15:0] Y_LAST_DEF = 16'h00ff;
    // extra cycles for window accesses
    localparam logic [1:0] EXTRA_FAST = 2'h1;
    localparam logic [1:0] EXTRA_SLOW = 2'h2;
    localparam logic [1:0] EXTRA_NONE = 2'h0;
    // request kinds
    typedef enum logic [2:0] {
        OP_DATA_READ,
        OP_TABLE_READ_LOW,
        OP_TABLE_READ_HIGH,
        OP_TABLE_WRITE_LOW,
        OP_TABLE_WRITE_HIGH
    } psda_op_t;
    // pointer register used by a dual-operand access
    typedef enum logic [1:0] {
        PTR_X_POINTER_FIRST,
        PTR_X_POINTER_SECOND,
        PTR_Y_POINTER_FIRST,
        PTR_Y_POINTER_SECOND
    } psda_ptr_t;
    // source of the x-path answer
    typedef enum logic [1:0] {
        SRC_TABLE,
        SRC_WINDOW,
        SRC_DATA,
        SRC_ZERO
    } psda_src_t;
endpackage

// ==== hw/psda_access.sv ====
// program space data access: table reads and writes, data window into
// program memory, window stall cycles and x/y region decode.
// assumes program and data memories answer reads one cycle after the strobe.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module psda_access #(
    parameter logic [15:0] DM_BYTES = psda_pkg::DM_BYTES_DEF,
    parameter logic [15:0] Y_FIRST = psda_pkg::Y_FIRST_DEF,
    parameter logic [15:0] Y_LAST = psda_pkg::Y_LAST_DEF
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // register port
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // core request
    input wire logic i_req,
    input wire psda_pkg::psda_op_t i_op,
    input wire logic i_byte,
    input wire logic [15:0] i_ea,
    input wire logic [15:0] i_wdata,
    input wire logic i_dual,
    input wire psda_pkg::psda_ptr_t i_ptr,
    input wire logic [15:0] i_ea_y,
    input wire logic i_fast_class,
    input wire logic i_in_repeat,
    input wire logic i_rep_special,
    output logic o_busy,
    output logic o_ack,
    output logic [15:0] o_xdata,
    output logic [15:0] o_ydata,
    // program memory
    output logic [23:0] o_pm_addr,
    output logic o_pm_rd,
    output logic o_pm_wr,
    output logic [2:0] o_pm_wmask,
    output logic [23:0] o_pm_wdata,
    input wire logic [23:0] i_pm_rdata,
    // data memory, x and y paths
    output logic [15:0] o_dm_addr,
    output logic o_dm_rd,
    input wire logic [15:0] i_dm_rdata,
    output logic [15:0] o_ym_addr,
    output logic o_ym_rd,
    input wire logic [15:0] i_ym_rdata
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_CAPTURE, ST_STALL, ST_DONE} psda_st_t;
    typedef struct packed {
        psda_st_t st;
        logic win_en;
        logic [7:0] wpage;
        logic [7:0] tpage;
        psda_pkg::psda_op_t op;
        logic byte_op;
        logic sel;
        psda_pkg::psda_src_t src;
        logic y_rd;
        logic y_zero;
        logic [1:0] extra;
        logic [1:0] cnt;
        logic [23:0] pm_addr;
        logic pm_rd;
        logic pm_wr;
        logic [2:0] pm_wmask;
        logic [23:0] pm_wdata;
        logic [15:0] dm_addr;
        logic dm_rd;
        logic [15:0] ym_addr;
        logic [15:0] xdata;
        logic [15:0] ydata;
        logic [7:0] rdata;
        logic [1:0] last_extra;
        logic last_win;
        logic last_zero;
    } psda_state_t;

    psda_state_t s_q;
    psda_state_t s_d;
    logic is_table;
    logic is_write;
    logic win_hit;
    logic in_y;
    logic in_mem;
    logic y_ptr;
    logic x_ok;
    logic x_in_y;
    logic [1:0] extra_w;
    logic [15:0] pm_lo;
    logic [7:0] pm_hi;

    // ****************************************
    // request decode
    // ****************************************
    // classify the incoming request
    always_comb begin
        is_table = (i_op != psda_pkg::OP_DATA_READ);
        is_write = (i_op == psda_pkg::OP_TABLE_WRITE_LOW) || (i_op == psda_pkg::OP_TABLE_WRITE_HIGH);
        // window test, table ops bypass it
        win_hit = !is_table && s_q.win_en && i_ea[15];
        // y region sits inside the lower half
        in_y = !i_ea_y[15] && (i_ea_y >= Y_FIRST) && (i_ea_y <= Y_LAST);
        in_mem = (i_ea < DM_BYTES);
        y_ptr = (i_ptr == psda_pkg::PTR_Y_POINTER_FIRST) || (i_ptr == psda_pkg::PTR_Y_POINTER_SECOND);
        // dual op: x pointers stay out of y, y pointers stay inside it
        x_in_y = (i_ea >= Y_FIRST) && (i_ea <= Y_LAST);
        x_ok = in_mem && !(i_dual && (y_ptr != x_in_y));
        if (!win_hit) begin
            extra_w = psda_pkg::EXTRA_NONE;
        end else if (i_in_repeat) begin
            extra_w = i_rep_special ? psda_pkg::EXTRA_SLOW : psda_pkg::EXTRA_NONE;
        end else begin
            extra_w = i_fast_class ? psda_pkg::EXTRA_FAST : psda_pkg::EXTRA_SLOW;
        end
    end

    // program word halves for the read mux
    assign pm_lo = i_pm_rdata[15:0];
    assign pm_hi = i_pm_rdata[23:16];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.pm_rd = 1'b0;
        s_d.pm_wr = 1'b0;
        s_d.dm_rd = 1'b0;
        s_d.y_rd = 1'b0;
        // register writes
        if (i_reg_wr) begin
            if (i_reg_addr == psda_pkg::REG_CORE_CTRL) begin
                s_d.win_en = i_reg_wdata[psda_pkg::WIN_EN_BIT];
            end else if (i_reg_addr == psda_pkg::REG_WIN_PAGE) begin
                s_d.wpage = i_reg_wdata;
            end else if (i_reg_addr == psda_pkg::REG_TBL_PAGE) begin
                s_d.tpage = i_reg_wdata;
            end
        end
        // register reads, answered the next cycle
        s_d.rdata = 8'h00;
        if (i_reg_rd) begin
            if (i_reg_addr == psda_pkg::REG_CORE_CTRL) begin
                s_d.rdata[psda_pkg::WIN_EN_BIT] = s_q.win_en;
            end else if (i_reg_addr == psda_pkg::REG_WIN_PAGE) begin
                s_d.rdata = s_q.wpage;
            end else if (i_reg_addr == psda_pkg::REG_TBL_PAGE) begin
                s_d.rdata = s_q.tpage;
            end else if (i_reg_addr == psda_pkg::REG_STATUS) begin
                s_d.rdata[1:0] = s_q.last_extra;
                s_d.rdata[psda_pkg::ST_WIN_BIT] = s_q.last_win;
                s_d.rdata[psda_pkg::ST_ZERO_BIT] = s_q.last_zero;
                s_d.rdata[psda_pkg::ST_BUSY_BIT] = (s_q.st != ST_IDLE);
            end
        end
        case (s_q.st)
            ST_IDLE: begin
                if (i_req) begin
                    s_d.st = ST_ISSUE;
                    s_d.op = i_op;
                    s_d.byte_op = i_byte;
                    s_d.sel = i_ea[0];
                    s_d.extra = extra_w;
                    s_d.cnt = extra_w;
                    s_d.y_zero = 1'b0;
                    if (is_table) begin
                        // page over address, bit 0 stays byte select
                        s_d.src = psda_pkg::SRC_TABLE;
                        s_d.pm_addr = {s_q.tpage, i_ea};
                        s_d.pm_rd = !is_write;
                        s_d.pm_wr = is_write;
                        // only high table writes reach the upper byte
                        if (i_op == psda_pkg::OP_TABLE_WRITE_HIGH) begin
                            s_d.pm_wmask = (i_byte && i_ea[0]) ? 3'h0 : 3'h4;
                            s_d.pm_wdata = {i_wdata[7:0], 16'h0000};
                        end else begin
                            s_d.pm_wmask = !i_byte ? 3'h3 : (i_ea[0] ? 3'h2 : 3'h1);
                            s_d.pm_wdata = i_byte ? {8'h00, i_wdata[7:0], i_wdata[7:0]} : {8'h00, i_wdata};
                        end
                    end else if (win_hit) begin
                        s_d.src = psda_pkg::SRC_WINDOW;
                        s_d.pm_addr = {1'b0, s_q.wpage, i_ea[14:0]};
                        s_d.pm_rd = 1'b1;
                    end else if (x_ok) begin
                        s_d.src = psda_pkg::SRC_DATA;
                        s_d.dm_addr = i_ea;
                        s_d.dm_rd = 1'b1;
                    end else begin
                        s_d.src = psda_pkg::SRC_ZERO;
                    end
                    // second path only for dual-operand reads
                    if (i_dual && !is_table) begin
                        s_d.ym_addr = i_ea_y;
                        s_d.y_rd = in_y;
                        // y pointers outside y read zero
                        s_d.y_zero = !in_y;
                    end
                end
            end
            ST_ISSUE: begin
                s_d.st = ST_CAPTURE;
            end
            ST_CAPTURE: begin
                s_d.st = (s_q.cnt != 2'h0) ? ST_STALL : ST_DONE;
                s_d.xdata = 16'h0000;
                case (s_q.src)
                    psda_pkg::SRC_TABLE: begin
                        if (s_q.op == psda_pkg::OP_TABLE_READ_LOW) begin
                            // low word or one of its bytes
                            if (!s_q.byte_op) begin
                                s_d.xdata = pm_lo;
                            end else begin
                                s_d.xdata = {8'h00, s_q.sel ? pm_lo[15:8] : pm_lo[7:0]};
                            end
                        end else if (s_q.op == psda_pkg::OP_TABLE_READ_HIGH) begin
                            // upper byte, phantom byte is zero
                            if (!s_q.byte_op || !s_q.sel) begin
                                s_d.xdata = {8'h00, pm_hi};
                            end
                        end
                    end
                    psda_pkg::SRC_WINDOW: begin
                        s_d.xdata = (s_q.byte_op) ? {8'h00, s_q.sel ? pm_lo[15:8] : pm_lo[7:0]} : pm_lo;
                    end
                    psda_pkg::SRC_DATA: begin
                        s_d.xdata = (s_q.byte_op) ? {8'h00, s_q.sel ? i_dm_rdata[15:8] : i_dm_rdata[7:0]} : i_dm_rdata;
                    end
                    default: begin
                        s_d.xdata = 16'h0000;
                    end
                endcase
                s_d.ydata = s_q.y_zero ? 16'h0000 : i_ym_rdata;
                s_d.last_extra = s_q.extra;
                s_d.last_win = (s_q.src == psda_pkg::SRC_WINDOW);
                s_d.last_zero = (s_q.src == psda_pkg::SRC_ZERO) || s_q.y_zero;
            end
            ST_STALL: begin
                // burn the window cost
                s_d.cnt = s_q.cnt - 2'h1;
                if (s_q.cnt == 2'h1) begin
                    s_d.st = ST_DONE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.win_en <= psda_pkg::WIN_EN_RST;
            s_q.wpage <= psda_pkg::WIN_PAGE_RST;
            s_q.tpage <= psda_pkg::TBL_PAGE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign o_reg_rdata = s_q.rdata;
    assign o_busy = (s_q.st != ST_IDLE);
    assign o_ack = (s_q.st == ST_DONE);
    assign o_xdata = s_q.xdata;
    assign o_ydata = s_q.ydata;
    assign o_pm_addr = s_q.pm_addr;
    assign o_pm_rd = s_q.pm_rd;
    assign o_pm_wr = s_q.pm_wr;
    assign o_pm_wmask = s_q.pm_wmask;
    assign o_pm_wdata = s_q.pm_wdata;
    assign o_dm_addr = s_q.dm_addr;
    assign o_dm_rd = s_q.dm_rd;
    assign o_ym_addr = s_q.ym_addr;
    assign o_ym_rd = s_q.y_rd;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // request-time address and cost checks
    win_addr_a: assert property (i_req && !o_busy && win_hit
        |=> o_pm_rd && o_pm_addr == {1'b0, s_q.wpage, $past(i_ea[14:0])})
        else $error("window address wrong");
    win_redirect_a: assert property (i_req && !o_busy && i_op == psda_pkg::OP_DATA_READ
        && s_q.win_en && i_ea[15] |=> o_pm_rd && !o_dm_rd)
        else $error("window access not redirected");
    table_nowin_a: assert property (i_req && !o_busy && i_op != psda_pkg::OP_DATA_READ
        |=> o_pm_addr == {s_q.tpage, $past(i_ea)})
        else $error("table access went through window");
    fast_cost_a: assert property (i_req && !o_busy && win_hit && !i_in_repeat
        && i_fast_class |-> ##4 o_ack)
        else $error("fast window cost not one cycle");
    slow_cost_a: assert property (i_req && !o_busy && win_hit && !i_in_repeat
        && !i_fast_class |-> ##4 !o_ack ##1 o_ack)
        else $error("slow window cost not two cycles");
    rep_plain_a: assert property (i_req && !o_busy && win_hit && i_in_repeat
        && !i_rep_special |-> ##3 o_ack)
        else $error("repeat iteration stalled");
    rep_special_a: assert property (i_req && !o_busy && win_hit && i_in_repeat
        && i_rep_special |-> ##5 o_ack)
        else $error("special iteration cost wrong");

    // returned data checks
    high_zero_a: assert property (s_q.st == ST_CAPTURE && s_q.op == psda_pkg::OP_TABLE_READ_HIGH
        |=> o_xdata[15:8] == 8'h00)
        else $error("high read upper byte not zero");
    high_word_a: assert property (s_q.st == ST_CAPTURE && !s_q.byte_op
        && s_q.src == psda_pkg::SRC_TABLE && s_q.op == psda_pkg::OP_TABLE_READ_HIGH
        |=> o_xdata[7:0] == $past(i_pm_rdata[23:16]))
        else $error("high word read wrong");
    high_phantom_a: assert property (s_q.st == ST_CAPTURE && s_q.byte_op && s_q.sel
        && s_q.op == psda_pkg::OP_TABLE_READ_HIGH |=> o_xdata == 16'h0000)
        else $error("phantom byte not zero");
    low_word_a: assert property (s_q.st == ST_CAPTURE && !s_q.byte_op
        && s_q.src == psda_pkg::SRC_TABLE && s_q.op == psda_pkg::OP_TABLE_READ_LOW
        |=> o_xdata == $past(i_pm_rdata[15:0]))
        else $error("low word read wrong");
    low_byte_a: assert property (s_q.st == ST_CAPTURE && s_q.byte_op
        && s_q.src == psda_pkg::SRC_TABLE && s_q.op == psda_pkg::OP_TABLE_READ_LOW
        |=> o_xdata == {8'h00, ($past(s_q.sel) ? $past(i_pm_rdata[15:8]) : $past(i_pm_rdata[7:0]))})
        else $error("low byte read wrong");
    win_low_a: assert property (s_q.st == ST_CAPTURE && !s_q.byte_op
        && s_q.src == psda_pkg::SRC_WINDOW |=> o_xdata == $past(i_pm_rdata[15:0]))
        else $error("window data not low word");
    zero_out_a: assert property (s_q.st == ST_CAPTURE && s_q.src == psda_pkg::SRC_ZERO
        |=> o_xdata == 16'h0000)
        else $error("invalid access not zero");

    // region and lane checks
    upper_lane_a: assert property (o_pm_wr && o_pm_wmask[2]
        |-> s_q.op == psda_pkg::OP_TABLE_WRITE_HIGH)
        else $error("upper byte written by wrong op");
    y_upper_a: assert property (o_ym_rd |-> !o_ym_addr[15])
        else $error("y path reached upper half");
    dm_range_a: assert property (o_dm_rd |-> o_dm_addr < DM_BYTES)
        else $error("data read outside memory");
    single_path_a: assert property (o_ym_rd |-> $past(i_dual))
        else $error("y path used outside dual operand");

    cov_window_c: cover property (o_ack && s_q.last_win);
    cov_table_c: cover property (o_pm_wr);
    cov_dual_c: cover property (o_ym_rd && o_dm_rd);
    cov_slow_c: cover property (o_ack && s_q.last_extra == psda_pkg::EXTRA_SLOW);
    cov_zero_c: cover property (o_ack && s_q.last_zero);
endmodule
`default_nettype wire

// ==== tb/psda_mem_model.sv ====
// memory partner: program flash and the x and y data memories
// assumes reads are strobed one cycle and answered in the next cycle only
`timescale 1ns/1ns
`default_nettype none
module psda_mem_model (
    // clock
    input wire logic i_clk,
    // program memory
    input wire logic [23:0] i_pm_addr,
    input wire logic i_pm_rd,
    input wire logic i_pm_wr,
    input wire logic [2:0] i_pm_wmask,
    input wire logic [23:0] i_pm_wdata,
    output logic [23:0] o_pm_rdata,
    // data memories
    input wire logic [15:0] i_dm_addr,
    input wire logic i_dm_rd,
    output logic [15:0] o_dm_rdata,
    input wire logic [15:0] i_ym_addr,
    input wire logic i_ym_rd,
    output logic [15:0] o_ym_rdata
);
    // ************************************************
    // storage and answers
    // ************************************************
    logic [23:0] mem [16];
    int b;
    // word i holds a pattern tagged by its index
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = {4'ha, 4'(i), 4'hb, 4'(i), 4'hc, 4'(i)};
        end
        o_pm_rdata = 24'h000000;
        o_dm_rdata = 16'h0000;
        o_ym_rdata = 16'h0000;
    end
    // word index from address bits above bit 0
    // idle data lines show the inverse of their last value
    always @(posedge i_clk) begin
        o_pm_rdata <= i_pm_rd ? mem[i_pm_addr[4:1]] : ~o_pm_rdata;
        o_dm_rdata <= i_dm_rd ? {8'hd0, i_dm_addr[7:0]} : ~o_dm_rdata;
        o_ym_rdata <= i_ym_rd ? {8'he0, i_ym_addr[7:0]} : ~o_ym_rdata;
        if (i_pm_wr) begin
            for (b = 0; b < 3; b++) begin
                if (i_pm_wmask[b]) begin
                    mem[i_pm_addr[4:1]][8*b +: 8] <= i_pm_wdata[8*b +: 8];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/program_space_data_access_bench.sv ====
// self-checking bench for the program space data access block
// assumes the memory partner answers reads in the cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
module program_space_data_access_bench;
    // ************************************************
    // signals and instances
    // ************************************************
    logic i_clk, i_reset, i_reg_wr, i_reg_rd, i_req, i_byte, i_dual, i_fast_class, i_in_repeat, i_rep_special;
    logic [3:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata;
    psda_pkg::psda_op_t i_op;
    psda_pkg::psda_ptr_t i_ptr;
    logic [15:0] i_ea, i_wdata, i_ea_y, o_xdata, o_ydata, o_dm_addr, o_ym_addr, dm_rdata, ym_rdata, xd, yd;
    logic o_busy, o_ack, o_pm_rd, o_pm_wr, o_dm_rd, o_ym_rd, prd, ysn;
    logic [2:0] o_pm_wmask, wm;
    logic [23:0] o_pm_addr, o_pm_wdata, pm_rdata, pa;
    int errors, n_tests, lat;
    psda_access uut (.i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_req(i_req), .i_op(i_op),
        .i_byte(i_byte), .i_ea(i_ea), .i_wdata(i_wdata), .i_dual(i_dual), .i_ptr(i_ptr), .i_ea_y(i_ea_y),
        .i_fast_class(i_fast_class), .i_in_repeat(i_in_repeat), .i_rep_special(i_rep_special), .o_busy(o_busy),
        .o_ack(o_ack), .o_xdata(o_xdata), .o_ydata(o_ydata), .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd),
        .o_pm_wr(o_pm_wr), .o_pm_wmask(o_pm_wmask), .o_pm_wdata(o_pm_wdata), .i_pm_rdata(pm_rdata),
        .o_dm_addr(o_dm_addr), .o_dm_rd(o_dm_rd), .i_dm_rdata(dm_rdata), .o_ym_addr(o_ym_addr),
        .o_ym_rd(o_ym_rd), .i_ym_rdata(ym_rdata));
    psda_mem_model mem (.i_clk(i_clk), .i_pm_addr(o_pm_addr), .i_pm_rd(o_pm_rd), .i_pm_wr(o_pm_wr),
        .i_pm_wmask(o_pm_wmask), .i_pm_wdata(o_pm_wdata), .o_pm_rdata(pm_rdata), .i_dm_addr(o_dm_addr),
        .i_dm_rd(o_dm_rd), .o_dm_rdata(dm_rdata), .i_ym_addr(o_ym_addr), .i_ym_rd(o_ym_rd),
        .o_ym_rdata(ym_rdata));
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        check(24'(o_reg_rdata), 24'(e));
    endtask
    task automatic mode(input logic f, input logic r, input logic s, input logic d);
        @(posedge i_clk);
        i_fast_class <= f;
        i_in_repeat <= r;
        i_rep_special <= s;
        i_dual <= d;
    endtask
    // one request; records program strobes, y strobe, latency and data
    task automatic go(input psda_pkg::psda_op_t op, input logic by, input logic [15:0] ea);
        int k;
        prd = 1'b0;
        ysn = 1'b0;
        wm = 3'h0;
        pa = 24'h000000;
        @(posedge i_clk);
        i_req <= 1'b1;
        i_op <= op;
        i_byte <= by;
        i_ea <= ea;
        @(posedge i_clk);
        i_req <= 1'b0;
        #1;
        k = 1;
        while (o_ack !== 1'b1 && k < 20) begin
            if (o_pm_rd === 1'b1) begin
                prd = 1'b1;
                pa = o_pm_addr;
            end
            if (o_pm_wr === 1'b1) wm = o_pm_wmask;
            if (o_ym_rd === 1'b1) ysn = 1'b1;
            @(posedge i_clk);
            #1;
            k++;
        end
        if (o_ack !== 1'b1) begin
            errors++;
            $display("MISMATCH at %0t: no acknowledge", $time);
            conclude();
        end else begin
            lat = k;
            xd = o_xdata;
            yd = o_ydata;
        end
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_regs();
        reg_rd(psda_pkg::REG_CORE_CTRL, 8'h00);
        reg_rd(psda_pkg::REG_WIN_PAGE, psda_pkg::WIN_PAGE_RST);
        reg_wr(4'h9, 8'hff);
        reg_rd(4'h9, 8'h00);
        reg_wr(psda_pkg::REG_TBL_PAGE, 8'h81);
        reg_rd(psda_pkg::REG_TBL_PAGE, 8'h81);
    endtask
    task automatic t_table();
        go(psda_pkg::OP_TABLE_READ_LOW, 1'b0, 16'h0006);
        check(pa, 24'h810006);
        check(24'(lat), 24'd3);
        check(24'(xd), 24'h00b3c3);
        go(psda_pkg::OP_TABLE_READ_LOW, 1'b1, 16'h0006);
        check(24'(xd), 24'h0000c3);
        go(psda_pkg::OP_TABLE_READ_LOW, 1'b1, 16'h0007);
        check(24'(xd), 24'h0000b3);
        go(psda_pkg::OP_TABLE_READ_HIGH, 1'b0, 16'h0006);
        check(24'(xd), 24'h0000a3);
        go(psda_pkg::OP_TABLE_READ_HIGH, 1'b1, 16'h0006);
        check(24'(xd), 24'h0000a3);
        go(psda_pkg::OP_TABLE_READ_HIGH, 1'b1, 16'h0007);
        check(24'(xd), 24'h000000);
    endtask
    task automatic t_write();
        @(posedge i_clk);
        i_wdata <= 16'h1234;
        go(psda_pkg::OP_TABLE_WRITE_LOW, 1'b0, 16'h000a);
        check(24'(wm), 24'h3);
        @(posedge i_clk);
        i_wdata <= 16'h0077;
        go(psda_pkg::OP_TABLE_WRITE_HIGH, 1'b0, 16'h000a);
        check(24'(wm), 24'h4);
        @(posedge i_clk);
        i_wdata <= 16'h0055;
        go(psda_pkg::OP_TABLE_WRITE_HIGH, 1'b1, 16'h000b);
        check(24'(wm), 24'h0);
        go(psda_pkg::OP_TABLE_READ_LOW, 1'b0, 16'h000a);
        check(24'(xd), 24'h001234);
        go(psda_pkg::OP_TABLE_READ_HIGH, 1'b0, 16'h000a);
        check(24'(xd), 24'h000077);
    endtask
    task automatic wcase(input logic f, input logic r, input logic s, input int e);
        mode(f, r, s, 1'b0);
        go(psda_pkg::OP_DATA_READ, 1'b0, 16'h8006);
        check(pa, 24'h2d0006);
        check(24'(xd), 24'h00b3c3);
        check(24'(lat), 24'(e));
    endtask
    task automatic t_window();
        reg_wr(psda_pkg::REG_CORE_CTRL, 8'h01);
        reg_rd(psda_pkg::REG_CORE_CTRL, 8'h01);
        reg_wr(psda_pkg::REG_WIN_PAGE, 8'h5a);
        wcase(1'b1, 1'b0, 1'b0, 4);
        reg_rd(psda_pkg::REG_STATUS, 8'h05);
        wcase(1'b0, 1'b0, 1'b0, 5);
        wcase(1'b0, 1'b1, 1'b1, 5);
        wcase(1'b1, 1'b1, 1'b1, 5);
        wcase(1'b0, 1'b1, 1'b0, 3);
        go(psda_pkg::OP_DATA_READ, 1'b1, 16'h8007);
        check(24'(xd), 24'h0000b3);
        reg_wr(psda_pkg::REG_WIN_PAGE, 8'hff);
        go(psda_pkg::OP_DATA_READ, 1'b0, 16'hfffe);
        check(pa, 24'h7ffffe);
        go(psda_pkg::OP_TABLE_READ_LOW, 1'b0, 16'h8006);
        check(pa, 24'h818006);
        reg_wr(psda_pkg::REG_CORE_CTRL, 8'h00);
        go(psda_pkg::OP_DATA_READ, 1'b0, 16'h8006);
        check(24'(prd), 24'h0);
        check(24'(xd), 24'h000000);
        reg_rd(psda_pkg::REG_STATUS, 8'h08);
    endtask
    task automatic t_dual();
        mode(1'b1, 1'b0, 1'b0, 1'b1);
        i_ptr <= psda_pkg::PTR_X_POINTER_FIRST;
        i_ea_y <= 16'h0090;
        go(psda_pkg::OP_DATA_READ, 1'b0, 16'h0010);
        check(24'(xd), 24'h00d010);
        check(24'(yd), 24'h00e090);
        check(24'(ysn), 24'h1);
        go(psda_pkg::OP_DATA_READ, 1'b0, 16'h0090);
        check(24'(xd), 24'h000000);
        @(posedge i_clk);
        i_ptr <= psda_pkg::PTR_Y_POINTER_FIRST;
        i_ea_y <= 16'h8000;
        go(psda_pkg::OP_DATA_READ, 1'b0, 16'h0010);
        check(24'(xd), 24'h000000);
        check(24'(yd), 24'h000000);
        go(psda_pkg::OP_DATA_READ, 1'b0, 16'h0090);
        check(24'(xd), 24'h00d090);
        mode(1'b0, 1'b0, 1'b0, 1'b0);
        go(psda_pkg::OP_DATA_READ, 1'b0, 16'h0090);
        check(24'(xd), 24'h00d090);
        check(24'(ysn), 24'h0);
        go(psda_pkg::OP_DATA_READ, 1'b0, 16'h0200);
        check(24'(xd), 24'h000000);
    endtask
    // ************************************************
    // clock and main sequence
    // ************************************************
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        errors = 0;
        n_tests = 0;
        i_reset = 1'b1;
        {i_reg_wr, i_reg_rd, i_req, i_byte, i_dual, i_fast_class, i_in_repeat, i_rep_special} = 8'h00;
        i_reg_addr = 4'h0;
        i_reg_wdata = 8'h00;
        i_op = psda_pkg::OP_DATA_READ;
        i_ptr = psda_pkg::PTR_X_POINTER_FIRST;
        i_ea = 16'h0000;
        i_wdata = 16'h0000;
        i_ea_y = 16'h0000;
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        t_regs();
        t_table();
        t_write();
        t_window();
        t_dual();
        conclude();
    end
endmodule
`default_nettype wire
